/* File: rtl/ccms_nco.sv */
// Phase-accumulating synthesiser producing the multiplied CPU clock edges
`timescale 1ns/1ps
module ccms_nco #(
	parameter int PERIOD_W = 12
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Control link
	ccms_nco_if.gen nco
);
	localparam int AW = PERIOD_W + 1;

	logic [AW-1:0] acc;
	logic [AW-1:0] next_acc;
	logic toggle;
	logic next_toggle;
	logic [AW-1:0] sum;
	logic [AW-1:0] per;

	// ----------------------------------------------------------------
	// Accumulator
	// ----------------------------------------------------------------
	// Each reference cycle adds 2F; one oscillator period worth of phase
	// produces exactly 2F edges, so the output stays locked to the input.
	always_comb begin
		sum = acc + AW'(nco.halves);
		per = AW'(nco.period);
		next_acc = acc;
		next_toggle = 1'b0;
		if (!nco.enable || nco.period == '0) begin
			next_acc = '0;
		end else if (sum >= per) begin
			next_acc = sum - per;
			next_toggle = 1'b1;
		end else begin
			next_acc = sum;
		end
		// Resync keeps a residual phase below the period and zeroes one at or
		// above it, so a fresh period estimate bends the rate without a jump
		if (nco.enable && nco.sync && next_acc >= per) begin
			next_acc = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			acc <= '0;
			toggle <= 1'b0;
		end else begin
			acc <= next_acc;
			toggle <= next_toggle;
		end
	end

	assign nco.toggle = toggle;

endmodule

/* File: rtl/ccms_nco_if.sv */
// Link between the mode controller and the frequency synthesiser
`timescale 1ns/1ps
interface ccms_nco_if #(
	parameter int PERIOD_W = 12
);
	logic enable;
	logic sync;
	logic [PERIOD_W-1:0] period;
	logic [3:0] halves;
	logic toggle;

	modport ctrl (output enable, output sync, output period, output halves, input toggle);
	modport gen (input enable, input sync, input period, input halves, output toggle);
endinterface

/* File: rtl/ccms_pkg.sv */
// Shared constants, types and decode helpers for the CPU clock mode select block
package ccms_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] CCMS_OFF_LATCH = 8'h00;
	localparam logic [7:0] CCMS_OFF_RSTCTL = 8'h04;
	localparam logic [7:0] CCMS_OFF_CTRL = 8'h08;
	localparam logic [7:0] CCMS_OFF_STATUS = 8'h0C;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CCMS_SEL_MSB = 7;
	localparam int CCMS_SEL_LSB = 5;
	localparam int CCMS_CTRL_LOAD_BIT = 0;
	localparam int CCMS_RSTCTL_HI_LSB = 8;
	localparam int CCMS_STAT_KIND_LSB = 4;
	localparam int CCMS_STAT_PERIOD_LSB = 16;
	localparam logic [7:0] CCMS_LATCH_RST = 8'hFF;
	localparam logic [15:0] CCMS_RSTCTL_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	// Edges after reset release before pin levels have passed the synchroniser
	localparam logic [1:0] CCMS_CAP_WAIT = 2'h3;

	// ----------------------------------------------------------------
	// Select encodings and half-periods per oscillator period
	// ----------------------------------------------------------------
	localparam logic [2:0] CCMS_SEL_X4 = 3'h7;
	localparam logic [2:0] CCMS_SEL_X3 = 3'h6;
	localparam logic [2:0] CCMS_SEL_X2 = 3'h5;
	localparam logic [2:0] CCMS_SEL_X5 = 3'h4;
	localparam logic [2:0] CCMS_SEL_DIRECT = 3'h3;
	localparam logic [2:0] CCMS_SEL_X1P5 = 3'h2;
	localparam logic [2:0] CCMS_SEL_PRESCALE = 3'h1;
	localparam logic [2:0] CCMS_SEL_X2P5 = 3'h0;

	typedef enum logic [1:0] {
		CCMS_KIND_PLL,
		CCMS_KIND_DIRECT,
		CCMS_KIND_PRESCALE
	} ccms_kind_t;

	// Twice the factor, so 1.5 and 2.5 stay integral
	function automatic logic [3:0] ccms_halves(input logic [2:0] sel);
		logic [3:0] h;
		h = 4'h0;
		case (sel)
			CCMS_SEL_X4: h = 4'h8;
			CCMS_SEL_X3: h = 4'h6;
			CCMS_SEL_X2: h = 4'h4;
			CCMS_SEL_X5: h = 4'hA;
			CCMS_SEL_X1P5: h = 4'h3;
			CCMS_SEL_X2P5: h = 4'h5;
			default: h = 4'h0;
		endcase
		return h;
	endfunction

	function automatic ccms_kind_t ccms_kind(input logic [2:0] sel);
		ccms_kind_t k;
		k = CCMS_KIND_PLL;
		if (sel == CCMS_SEL_DIRECT) begin
			k = CCMS_KIND_DIRECT;
		end else if (sel == CCMS_SEL_PRESCALE) begin
			k = CCMS_KIND_PRESCALE;
		end
		return k;
	endfunction

endpackage

/* File: rtl/ccms_top.sv */
// CPU clock mode select: configuration latch, mode decode and CPU clock generation
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module ccms_top
	import ccms_pkg::*;
#(
	parameter int PERIOD_W = 12
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// APB slave
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins
	input wire logic osc_i,
	input wire logic [7:0] port0_upper_half_i,
	input wire logic emulation_mode_i,
	// Clock outputs
	output logic cpu_clk_o,
	output logic clock_half_period_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic osc_s1;
	logic osc_s2;
	logic osc_prev;
	logic [7:0] p0h_s1;
	logic [7:0] p0h_s2;
	logic emu_s1;
	logic emu_s2;
	logic osc_rise;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_prev <= 1'b0;
			p0h_s1 <= 8'h00;
			p0h_s2 <= 8'h00;
			emu_s1 <= 1'b0;
			emu_s2 <= 1'b0;
		end else begin
			osc_s1 <= osc_i;
			osc_s2 <= osc_s1;
			osc_prev <= osc_s2;
			p0h_s1 <= port0_upper_half_i;
			p0h_s2 <= p0h_s1;
			emu_s1 <= emulation_mode_i;
			emu_s2 <= emu_s1;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator edge detect
	// ----------------------------------------------------------------
	// Armed only once the pipeline holds real pin samples: a high
	// oscillator at reset release would otherwise fake a rising edge.
	logic [1:0] osc_warm;
	logic [1:0] next_osc_warm;
	logic osc_armed;

	always_comb begin
		next_osc_warm = osc_warm;
		if (osc_warm != CCMS_CAP_WAIT) begin
			next_osc_warm = osc_warm + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			osc_warm <= 2'h0;
		end else begin
			osc_warm <= next_osc_warm;
		end
	end

	assign osc_armed = (osc_warm == CCMS_CAP_WAIT);
	assign osc_rise = osc_armed && osc_s2 && !osc_prev;

	// ----------------------------------------------------------------
	// Configuration latch and registers
	// ----------------------------------------------------------------
	logic [7:0] reset_config_latch_high;
	logic [7:0] next_latch;
	logic [15:0] reset_control_register;
	logic [15:0] next_rstctl;
	logic [1:0] cap_wait;
	logic [1:0] next_cap_wait;
	logic [7:0] pin_view;
	logic wr_en;

	assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

	always_comb begin
		next_latch = reset_config_latch_high;
		next_rstctl = reset_control_register;
		next_cap_wait = cap_wait;
		pin_view = p0h_s2;
		// Emulation flips the level seen on the top select pin
		pin_view[CCMS_SEL_MSB] = p0h_s2[CCMS_SEL_MSB] ^ emu_s2;
		if (cap_wait != 2'h0) begin
			next_cap_wait = cap_wait - 2'h1;
			if (cap_wait == 2'h1) begin
				next_latch = pin_view;
			end
		end
		if (wr_en && paddr_i == CCMS_OFF_RSTCTL) begin
			next_rstctl = pwdata_i[15:0];
		end
		// A reload can lose to the capture: a write can complete on the second
		// edge after reset, and the capture on the third edge overwrites it.
		if (wr_en && paddr_i == CCMS_OFF_CTRL && pwdata_i[CCMS_CTRL_LOAD_BIT]) begin
			next_latch = reset_control_register[15:CCMS_RSTCTL_HI_LSB];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			reset_config_latch_high <= CCMS_LATCH_RST;
			reset_control_register <= CCMS_RSTCTL_RST;
			cap_wait <= CCMS_CAP_WAIT;
		end else begin
			reset_config_latch_high <= next_latch;
			reset_control_register <= next_rstctl;
			cap_wait <= next_cap_wait;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic [2:0] clock_source_select;
	ccms_kind_t kind;
	logic [3:0] halves;

	assign clock_source_select = reset_config_latch_high[CCMS_SEL_MSB:CCMS_SEL_LSB];
	assign kind = ccms_kind(clock_source_select);
	assign halves = ccms_halves(clock_source_select);

	// ----------------------------------------------------------------
	// Oscillator period measurement
	// ----------------------------------------------------------------
	logic [PERIOD_W-1:0] osc_cnt;
	logic [PERIOD_W-1:0] next_osc_cnt;
	logic [PERIOD_W-1:0] osc_period;
	logic [PERIOD_W-1:0] next_osc_period;
	logic osc_seen;
	logic next_osc_seen;

	always_comb begin
		next_osc_cnt = osc_cnt;
		next_osc_period = osc_period;
		next_osc_seen = osc_seen;
		if (osc_rise) begin
			// The count up to the first rise is partial and sets no period
			if (osc_seen) begin
				next_osc_period = osc_cnt + PERIOD_W'(1);
			end
			next_osc_seen = 1'b1;
			next_osc_cnt = '0;
		end else if (osc_cnt != '1) begin
			next_osc_cnt = osc_cnt + PERIOD_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			osc_cnt <= '0;
			osc_period <= '0;
			osc_seen <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_period <= next_osc_period;
			osc_seen <= next_osc_seen;
		end
	end

	// ----------------------------------------------------------------
	// Synthesiser
	// ----------------------------------------------------------------
	ccms_nco_if #(.PERIOD_W(PERIOD_W)) nco_bus();

	assign nco_bus.enable = (kind == CCMS_KIND_PLL);
	assign nco_bus.sync = osc_rise;
	assign nco_bus.period = osc_period;
	assign nco_bus.halves = halves;

	ccms_nco #(.PERIOD_W(PERIOD_W)) u_nco (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.nco(nco_bus)
	);

	// ----------------------------------------------------------------
	// CPU clock generation
	// ----------------------------------------------------------------
	logic cpu_clk;
	logic next_cpu_clk;
	logic half_pulse;
	logic next_half_pulse;

	always_comb begin
		next_cpu_clk = cpu_clk;
		case (kind)
			CCMS_KIND_DIRECT: begin
				next_cpu_clk = osc_s2;
			end
			CCMS_KIND_PRESCALE: begin
				if (osc_rise) begin
					next_cpu_clk = !cpu_clk;
				end
			end
			CCMS_KIND_PLL: begin
				if (nco_bus.toggle) begin
					next_cpu_clk = !cpu_clk;
				end
			end
			default: begin
				next_cpu_clk = cpu_clk;
			end
		endcase
		// Both edges count, each closing one half-period
		next_half_pulse = (next_cpu_clk != cpu_clk);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cpu_clk <= 1'b0;
			half_pulse <= 1'b0;
		end else begin
			cpu_clk <= next_cpu_clk;
			half_pulse <= next_half_pulse;
		end
	end

	assign cpu_clk_o = cpu_clk;
	assign clock_half_period_o = half_pulse;

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	// One wait-free access phase: data and error are prepared during setup
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pready;
	logic next_pready;
	logic pslverr;
	logic next_pslverr;
	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[2:0] = clock_source_select;
		status_word[CCMS_STAT_KIND_LSB +: 2] = kind;
		status_word[CCMS_STAT_PERIOD_LSB +: PERIOD_W] = osc_period;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel_i && !penable_i) begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			case (paddr_i)
				CCMS_OFF_LATCH: next_prdata = {24'h00_0000, reset_config_latch_high};
				CCMS_OFF_RSTCTL: next_prdata = {16'h0000, reset_control_register};
				CCMS_OFF_CTRL: next_prdata = 32'h0000_0000;
				CCMS_OFF_STATUS: next_prdata = status_word;
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign prdata_o = prdata;
	assign pready_o = pready;
	assign pslverr_o = pslverr;

endmodule

/* File: test/ccms_osc_model.sv */
// Oscillator pin model feeding the block's clock input
`timescale 1ns/1ps
module ccms_osc_model (
	// Clock
	input wire logic ref_clk_i,
	// Half period in reference cycles
	input wire logic [7:0] half_i,
	// Oscillator pin
	output logic osc_o
);
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		osc_o = 1'b0;
	end
	// Levels far above two ref cycles, so the input range suits every mode
	always @(posedge ref_clk_i) begin
		if (cnt + 8'h01 >= half_i) begin
			cnt <= 8'h00;
			osc_o <= ~osc_o;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

/* File: test/ccms_top_chk.sv */
// Port-level assertions for the CPU clock mode select block
`timescale 1ns/1ps
module ccms_top_chk
	import ccms_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// APB
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Clock outputs
	input wire logic cpu_clk_o,
	input wire logic clock_half_period_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [15:0] shadow;
	logic [15:0] next_shadow;
	logic rd;
	logic mapped;
	assign rd = pready_o && !pwrite_i;
	assign mapped = paddr_i inside {CCMS_OFF_LATCH, CCMS_OFF_RSTCTL, CCMS_OFF_CTRL, CCMS_OFF_STATUS};
	always_comb begin
		next_shadow = shadow;
		if (pready_o && pwrite_i && paddr_i == CCMS_OFF_RSTCTL) begin
			next_shadow = pwdata_i[15:0];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		shadow <= rst_b_i ? next_shadow : 16'h0000;
	end
	setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no answer after setup");
	ready_single_a: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (pready_o |-> pslverr_o == !mapped)
		else $error("error flag wrong for address");
	err_data_a: assert property (rd && pslverr_o |-> prdata_o == 32'h0000_0000)
		else $error("refused read not zero");
	reload_src_a: assert property (rd && paddr_i == CCMS_OFF_RSTCTL |-> prdata_o == {16'h0000, shadow})
		else $error("reset control readback wrong");
	ctrl_zero_a: assert property (rd && paddr_i == CCMS_OFF_CTRL |-> prdata_o == 32'h0000_0000)
		else $error("control register not zero");
	mode_kind_a: assert property (rd && paddr_i == CCMS_OFF_STATUS |-> prdata_o[5:4] ==
		(prdata_o[2:0] == 3'h3 ? 2'h1 : prdata_o[2:0] == 3'h1 ? 2'h2 : 2'h0))
		else $error("mode kind does not match select");
	half_tick_a: assert property (clock_half_period_o == (cpu_clk_o != $past(cpu_clk_o)))
		else $error("half period pulse not on clock edge");
	cover property (rd && pslverr_o);
	cover property (clock_half_period_o);
	cover property (pready_o && pwrite_i && paddr_i == CCMS_OFF_CTRL);
endmodule
bind ccms_top ccms_top_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_clk_o(cpu_clk_o),
	.clock_half_period_o(clock_half_period_o));

/* File: test/cpu_clock_mode_select_bench.sv */
// Self-checking bench for the CPU clock mode select block
`timescale 1ns/1ps
module cpu_clock_mode_select_bench;
	import ccms_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, emu, osc, cpu, half, pready, pslverr, e;
	logic [7:0] paddr, pins;
	logic [31:0] pwdata, prdata, r, d;
	logic [31:0] seed = 32'h0000_35ff;
	logic [4:0] dl;
	int errors = 0;
	int cmp_count = 0;
	int hv[8] = '{5, 1, 3, 2, 10, 4, 6, 8};
	int cnt, bad, tol;
	// Latch model: the newest expected content sits at the back
	logic [7:0] latch_q[$];
	ccms_top u_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .osc_i(osc), .port0_upper_half_i(pins),
		.emulation_mode_i(emu), .cpu_clk_o(cpu), .clock_half_period_o(half));
	ccms_osc_model u_osc (.ref_clk_i(clk), .half_i(8'h28), .osc_o(osc));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Holds the request until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		pins = 8'hFF;
		emu = 1'b0;
		repeat (20) @(posedge clk);
		for (int c = 0; c < 8; c++) begin
			d = xs();
			pins <= {c[2] ^ c[0], c[1:0], d[4:0]};
			emu <= c[0];
			@(posedge clk);
			rst_b <= 1'b0;
			repeat (3) @(posedge clk);
			rst_b <= 1'b1;
			repeat (4) @(posedge clk);
			latch_q.push_back({pins[7] ^ emu, pins[6:0]});
			apb(1'b0, CCMS_OFF_LATCH, 32'h0000_0000);
			chk(r, {24'h00_0000, latch_q[$]});
			chk(latch_q[$][7:5], c[2:0]);
			apb(1'b0, CCMS_OFF_STATUS, 32'h0000_0000);
			chk({r[5:4], r[2:0]}, {(c == 3) ? 2'h1 : (c == 1) ? 2'h2 : 2'h0, c[2:0]});
			repeat (240) @(posedge clk);
			@(posedge osc);
			{cnt, bad, dl} = '0;
			repeat (320) begin
				@(posedge clk);
				dl = {dl[3:0], osc};
				cnt += int'(half);
				if (c == 3 && cpu !== dl[3] && cpu !== dl[2]) bad++;
			end
			tol = (c == 1 || c == 3) ? 1 : 2;
			chk(cnt >= 4 * hv[c] - tol && cnt <= 4 * hv[c] + tol, 1);
			chk(bad, 0);
			apb(1'b0, CCMS_OFF_STATUS, 32'h0000_0000);
			chk(r[CCMS_STAT_PERIOD_LSB +: 12], 32'h0000_0050);
			$display("mode %0d done", c);
		end
		d = xs();
		apb(1'b1, CCMS_OFF_RSTCTL, d);
		apb(1'b0, CCMS_OFF_RSTCTL, 32'h0000_0000);
		chk(r, {16'h0000, d[15:0]});
		apb(1'b1, CCMS_OFF_CTRL, 32'h0000_0001);
		apb(1'b1, CCMS_OFF_LATCH, ~d);
		apb(1'b0, CCMS_OFF_LATCH, 32'h0000_0000);
		latch_q.push_back(d[15:8]);
		chk(r, {24'h00_0000, latch_q[$]});
		apb(1'b0, CCMS_OFF_STATUS, 32'h0000_0000);
		chk(r[2:0], d[15:13]);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk({e, r}, {1'b1, 32'h0000_0000});
		$display("reload and map test done");
		complete_run();
	end
endmodule
